// [kplc_keypad_lock.sv]
// Keypad code interpreter: self-destruct, admin setup, code checks, auto-lock
//
// The address map and the plain strobed port were left to the implementer.
`timescale 1ns/1ns
module kplc_keypad_lock
	import kplc_pkg::*;
#(
	parameter int ACK_CYCLES = kplc_pkg::ACK_CYC,
	parameter int BLINK_CYCLES = kplc_pkg::BLINK_CYC,
	parameter int SHIFT_HOLD_CYCLES = kplc_pkg::SHIFT_HOLD_CYC,
	parameter int MINUTE_CYCLES = kplc_pkg::MINUTE_CYC
) (
	input wire logic core_clk,
	input wire logic rst_b,
	input wire logic keyPress,
	input wire logic keyDigitValid,
	input wire logic [3:0] keyDigit,
	input wire logic keyShift,
	input wire logic keyUnlock,
	input wire logic shiftHeld,
	input wire logic dataActivity,
	input wire logic wipeEvent,
	input wire logic [3:0] regAddr,
	input wire logic [31:0] regWrData,
	input wire logic regWrEn,
	input wire logic regRdEn,
	output logic [31:0] regRdData,
	output logic ledRed,
	output logic ledGreen,
	output logic ledBlue,
	output logic driveUnlocked,
	output logic adminMode,
	output logic cryptoErase
);
	import kplc_pkg::*;

	kplc_state_t state_r, state_nxt, errRet_r, errTo;
	logic [31:0] stateCnt_r, blinkCnt_r, holdCnt_r, idleCyc_r;
	logic blinkPh_r;
	logic [6:0] idleMin_r, alMin_r;
	logic [3:0] alTens_r, alUnits_r;
	logic adminPresent_r, userPresent_r, sdPresent_r;
	logic [1:0] adminSlot_r, userSlot_r, sdSlot_r, scratchSlot_r;
	logic [6:0] lenOf_r [0:3];
	logic [6:0] entryLen_r;
	logic allSame_r, allAsc_r, allDesc_r, match_r, cmpPend_r;
	kplc_sym_t prevSym_r, pendSym_r, curSym, memRd;
	logic [1:0] refSlot;
	logic entryActive, matchNow, validNow, timedDone, holdDone;
	logic digitEv, unlockEv, shiftEv, shiftUnlockEv, setupEv, sdDelEv, alEnterEv;
	logic wipeAll, busWipe, codeWr, keyWr, memWrEn;
	logic [7:0] memWrAddr;
	kplc_sym_t memWrData;
	logic goErr, sdClr, sdFire, setupSave, adminCommit, alStore;
	logic [6:0] alValue;
	logic [31:0] dur;

	// Key combinations decoded at the press event
	assign curSym = {keyShift, keyDigit};
	assign digitEv = keyPress & keyDigitValid & ~keyUnlock;
	assign unlockEv = keyPress & keyUnlock & ~keyDigitValid & ~keyShift;
	assign shiftEv = keyPress & keyShift & ~keyDigitValid & ~keyUnlock;
	assign shiftUnlockEv = keyPress & keyShift & keyUnlock & ~keyDigitValid;
	assign setupEv = digitEv & keyShift & (keyDigit == KEY_SETUP);
	assign sdDelEv = digitEv & keyShift & (keyDigit == KEY_SD_DEL);
	assign alEnterEv = keyPress & keyUnlock & keyDigitValid & ~keyShift & (keyDigit == KEY_AUTOLOCK);

	assign busWipe = regWrEn & (regAddr == REG_CTRL) & regWrData[CTRL_WIPE_BIT];
	assign wipeAll = wipeEvent | busWipe;
	assign codeWr = regWrEn & (regAddr == REG_CODE);
	assign alValue = kplc_two_digit(alTens_r, alUnits_r);

	always_comb begin
		unique case (state_r)
			ST_SD_ENTRY: refSlot = sdSlot_r;
			ST_SETUP1, ST_SETUP2: refSlot = scratchSlot_r;
			default: refSlot = adminSlot_r;
		endcase
	end

	assign entryActive = (state_r == ST_SD_ENTRY) || (state_r == ST_SETUP1) || (state_r == ST_SETUP2)
		|| ((state_r == ST_LOCKED) && adminPresent_r);

	// Last symbol may still be in the compare pipe when unlock arrives
	assign matchNow = match_r & (~cmpPend_r | (memRd == pendSym_r)) & (entryLen_r == lenOf_r[refSlot]);
	assign validNow = (entryLen_r >= MIN_LEN) & (entryLen_r <= MAX_LEN)
		& ~allSame_r
		& ~allAsc_r & ~allDesc_r;

	always_comb begin
		unique case (state_r)
			ST_SDDEL_ACK, ST_SD_ACK, ST_SETUP_OK, ST_AL_ACK, ST_ERR: dur = 32'(ACK_CYCLES);
			ST_SETUP_BLINK: dur = 32'(BLINK_CYCLES);
			default: dur = 32'h0;
		endcase
	end
	assign timedDone = (dur != 32'h0) && (stateCnt_r >= dur - 32'h1);
	assign holdDone = shiftHeld && (holdCnt_r == 32'(SHIFT_HOLD_CYCLES - 1));

	always_comb begin
		state_nxt = state_r;
		errTo = ST_LOCKED;
		goErr = 1'b0;
		sdClr = 1'b0;
		sdFire = 1'b0;
		setupSave = 1'b0;
		adminCommit = 1'b0;
		alStore = 1'b0;
		unique case (state_r)
			ST_LOCKED: begin
				if (shiftUnlockEv && sdPresent_r) begin
					state_nxt = ST_SD_ENTRY;
				end else if (!adminPresent_r) begin
					if (setupEv) begin
						state_nxt = ST_SETUP1;
					end
				end else if (unlockEv) begin
					if (matchNow) begin
						state_nxt = ST_ADMIN;
					end else begin
						goErr = 1'b1;
					end
				end
			end
			ST_ADMIN: begin
				if (holdDone) begin
					state_nxt = ST_LOCKED;
				end else if (sdDelEv) begin
					state_nxt = ST_SDDEL_PEND;
				end else if (alEnterEv) begin
					state_nxt = ST_AL_TENS;
				end
			end
			ST_SDDEL_PEND: begin
				if (sdDelEv) begin
					state_nxt = ST_SDDEL_ACK;
					sdClr = 1'b1;
				end else if (keyPress) begin
					state_nxt = ST_ADMIN;
				end
			end
			ST_SD_ENTRY: begin
				if (unlockEv) begin
					if (matchNow) begin
						state_nxt = ST_SD_ACK;
						sdFire = 1'b1;
					end else begin
						goErr = 1'b1;
					end
				end
			end
			ST_SETUP1: begin
				if (unlockEv) begin
					if (validNow) begin
						state_nxt = ST_SETUP_BLINK;
						setupSave = 1'b1;
					end else begin
						goErr = 1'b1;
					end
				end
			end
			ST_SETUP2: begin
				if (unlockEv) begin
					if (matchNow) begin
						state_nxt = ST_SETUP_OK;
						adminCommit = 1'b1;
					end else begin
						goErr = 1'b1;
					end
				end
			end
			ST_AL_TENS, ST_AL_UNITS: begin
				errTo = ST_ADMIN;
				if (digitEv && !keyShift) begin
					state_nxt = (state_r == ST_AL_TENS) ? ST_AL_UNITS : ST_AL_COMMIT;
				end else if (keyPress) begin
					goErr = 1'b1;
				end
			end
			ST_AL_COMMIT: begin
				errTo = ST_ADMIN;
				if (shiftEv) begin
					if ((alValue == AL_OFF) || ((alValue >= AL_MIN) && (alValue <= AL_MAX))) begin
						state_nxt = ST_AL_ACK;
						alStore = 1'b1;
					end else begin
						goErr = 1'b1;
					end
				end else if (keyPress) begin
					goErr = 1'b1;
				end
			end
			ST_UNLOCKED: begin
				if ((alMin_r != AL_OFF) && (idleMin_r >= alMin_r)) begin
					state_nxt = ST_LOCKED;
				end
			end
			ST_SDDEL_ACK, ST_SETUP_OK, ST_AL_ACK: begin
				if (timedDone) begin
					state_nxt = ST_ADMIN;
				end
			end
			ST_SD_ACK: begin
				if (timedDone) begin
					state_nxt = ST_UNLOCKED;
				end
			end
			ST_SETUP_BLINK: begin
				if (timedDone) begin
					state_nxt = ST_SETUP2;
				end
			end
			ST_ERR: begin
				if (timedDone) begin
					state_nxt = errRet_r;
				end
			end
		endcase
		if (goErr) begin
			state_nxt = ST_ERR;
		end
		if (wipeAll) begin
			state_nxt = ST_LOCKED;
		end
	end

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			state_r <= ST_LOCKED;
			errRet_r <= ST_LOCKED;
		end else begin
			state_r <= state_nxt;
			if (goErr) begin
				errRet_r <= errTo;
			end
		end
	end

	// Timers: state dwell, blink phase, shift hold
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			stateCnt_r <= 32'h0;
			blinkCnt_r <= 32'h0;
			blinkPh_r <= 1'b0;
			holdCnt_r <= 32'h0;
		end else begin
			stateCnt_r <= (state_nxt != state_r) ? 32'h0 : stateCnt_r + 32'h1;
			if (blinkCnt_r >= 32'(BLINK_CYCLES - 1)) begin
				blinkCnt_r <= 32'h0;
				blinkPh_r <= ~blinkPh_r;
			end else begin
				blinkCnt_r <= blinkCnt_r + 32'h1;
			end
			if (!shiftHeld || (state_r != ST_ADMIN)) begin
				holdCnt_r <= 32'h0;
			end else if (!holdDone) begin
				holdCnt_r <= holdCnt_r + 32'h1;
			end
		end
	end

	// Entry tracking; shift bit is part of every symbol
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			entryLen_r <= 7'h0;
			allSame_r <= 1'b1;
			allAsc_r <= 1'b1;
			allDesc_r <= 1'b1;
			match_r <= 1'b1;
			cmpPend_r <= 1'b0;
			prevSym_r <= '0;
			pendSym_r <= '0;
		end else if (state_nxt != state_r) begin
			entryLen_r <= 7'h0;
			allSame_r <= 1'b1;
			allAsc_r <= 1'b1;
			allDesc_r <= 1'b1;
			match_r <= 1'b1;
			cmpPend_r <= 1'b0;
		end else begin
			cmpPend_r <= 1'b0;
			if (cmpPend_r) begin
				match_r <= match_r & (memRd == pendSym_r);
			end
			if (digitEv && entryActive) begin
				entryLen_r <= (entryLen_r >= LEN_OVER) ? LEN_OVER : 7'(entryLen_r + 7'h1);
				prevSym_r <= curSym;
				pendSym_r <= curSym;
				cmpPend_r <= (entryLen_r < MAX_LEN);
				if (entryLen_r == 7'h0) begin
					allAsc_r <= ~keyShift;
					allDesc_r <= ~keyShift;
				end else begin
					allSame_r <= allSame_r & (curSym == prevSym_r);
					allAsc_r <= allAsc_r & ~keyShift & (keyDigit == kplc_succ(prevSym_r[3:0]));
					allDesc_r <= allDesc_r & ~keyShift & (keyDigit == kplc_pred(prevSym_r[3:0]));
				end
			end
		end
	end

	// Key writes win the single write port; a colliding bus write is lost
	assign keyWr = digitEv && (state_r == ST_SETUP1) && (entryLen_r < MAX_LEN) && (state_nxt == state_r);
	assign memWrEn = keyWr | codeWr;
	assign memWrAddr = keyWr ? {scratchSlot_r, entryLen_r[5:0]} : {sdSlot_r, regWrData[CODE_IDX_LSB +: 6]};
	assign memWrData = keyWr ? curSym : regWrData[CODE_SYM_LSB +: 5];

	kplc_code_mem #(
		.WIDTH(5),
		.AW(8)
	) uCodeMem (
		.core_clk(core_clk),
		.wrEn(memWrEn),
		.wrAddr(memWrAddr),
		.wrData(memWrData),
		.rdAddr({refSlot, entryLen_r[5:0]}),
		.rdData(memRd)
	);

	// Stored codes: slot pointers swap so nothing is copied
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			adminPresent_r <= 1'b0;
			userPresent_r <= 1'b0;
			sdPresent_r <= 1'b0;
			adminSlot_r <= SLOT_ADMIN;
			userSlot_r <= SLOT_USER;
			sdSlot_r <= SLOT_SD;
			scratchSlot_r <= SLOT_SCRATCH;
			for (int i = 0; i < 4; i++) begin
				lenOf_r[i] <= 7'h0;
			end
		end else if (wipeAll) begin
			adminPresent_r <= 1'b0;
			userPresent_r <= 1'b0;
			sdPresent_r <= 1'b0;
		end else begin
			if (sdClr) begin
				sdPresent_r <= 1'b0;
			end
			if (sdFire) begin
				userSlot_r <= sdSlot_r;
				sdSlot_r <= userSlot_r;
				userPresent_r <= 1'b1;
				adminPresent_r <= 1'b0;
				sdPresent_r <= 1'b0;
			end
			if (setupSave) begin
				lenOf_r[scratchSlot_r] <= entryLen_r;
			end
			if (adminCommit) begin
				adminSlot_r <= scratchSlot_r;
				scratchSlot_r <= adminSlot_r;
				adminPresent_r <= 1'b1;
			end
			if (codeWr && regWrData[CODE_COMMIT_BIT]) begin
				lenOf_r[sdSlot_r] <= 7'({1'b0, regWrData[CODE_IDX_LSB +: 6]} + 7'h1);
				sdPresent_r <= 1'b1;
			end
		end
	end

	// Auto-lock value and idle timer
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			alMin_r <= AL_RESET;
			alTens_r <= 4'h0;
			alUnits_r <= 4'h0;
			idleCyc_r <= 32'h0;
			idleMin_r <= 7'h0;
		end else begin
			if (digitEv && (state_r == ST_AL_TENS)) begin
				alTens_r <= keyDigit;
			end
			if (digitEv && (state_r == ST_AL_UNITS)) begin
				alUnits_r <= keyDigit;
			end
			if (alStore) begin
				alMin_r <= alValue;
			end
			if ((state_r != ST_UNLOCKED) || dataActivity || (alMin_r == AL_OFF)) begin
				idleCyc_r <= 32'h0;
				idleMin_r <= 7'h0;
			end else if (idleCyc_r >= 32'(MINUTE_CYCLES - 1)) begin
				idleCyc_r <= 32'h0;
				idleMin_r <= (idleMin_r == AL_MAX) ? AL_MAX : 7'(idleMin_r + 7'h1);
			end else begin
				idleCyc_r <= idleCyc_r + 32'h1;
			end
		end
	end

	// Indicators and status outputs
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			ledRed <= 1'b0;
			ledGreen <= 1'b0;
			ledBlue <= 1'b0;
			driveUnlocked <= 1'b0;
			adminMode <= 1'b0;
			cryptoErase <= 1'b0;
		end else begin
			driveUnlocked <= (state_r == ST_UNLOCKED);
			adminMode <= (state_r == ST_ADMIN);
			cryptoErase <= sdFire | wipeAll;
			unique case (state_r)
				ST_LOCKED, ST_SDDEL_ACK: {ledRed, ledGreen, ledBlue} <= 3'b100;
				ST_ADMIN: {ledRed, ledGreen, ledBlue} <= 3'b001;
				ST_SDDEL_PEND: {ledRed, ledGreen, ledBlue} <= {blinkPh_r, 2'b00};
				ST_SD_ENTRY: {ledRed, ledGreen, ledBlue} <= {3{blinkPh_r}};
				ST_SD_ACK: {ledRed, ledGreen, ledBlue} <= {1'b0, blinkPh_r, 1'b0};
				ST_UNLOCKED, ST_SETUP_BLINK, ST_AL_ACK: {ledRed, ledGreen, ledBlue} <= 3'b010;
				ST_SETUP1, ST_SETUP2: {ledRed, ledGreen, ledBlue} <= {1'b0, blinkPh_r, 1'b1};
				ST_SETUP_OK: {ledRed, ledGreen, ledBlue} <= {2'b00, blinkPh_r};
				ST_AL_TENS, ST_AL_UNITS, ST_AL_COMMIT: {ledRed, ledGreen, ledBlue} <= {1'b0, blinkPh_r, blinkPh_r};
				ST_ERR: {ledRed, ledGreen, ledBlue} <= {blinkPh_r, ~blinkPh_r, 1'b0};
			endcase
		end
	end

	// Register read port, data valid only in the cycle after the strobe
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			regRdData <= 32'h0;
		end else if (regRdEn) begin
			unique case (regAddr)
				REG_STATUS: begin
					regRdData <= 32'h0;
					regRdData[ST_STATE_LSB +: 5] <= state_r;
					regRdData[ST_ADMIN_BIT] <= adminPresent_r;
					regRdData[ST_USER_BIT] <= userPresent_r;
					regRdData[ST_SD_BIT] <= sdPresent_r;
					regRdData[ST_UNLOCK_BIT] <= driveUnlocked;
				end
				REG_AUTOLOCK: regRdData <= {25'h0, alMin_r};
				default: regRdData <= 32'h0;
			endcase
		end else begin
			regRdData <= 32'h0;
		end
	end
endmodule // kplc_keypad_lock

// [kplc_pkg.sv]
// Shared constants, types and helpers for the keypad lock controller
package kplc_pkg;
	localparam int CLK_HZ = 25_000_000;
	localparam int ACK_MS = 1000;
	localparam int ACK_CYC = CLK_HZ / 1000 * ACK_MS;
	localparam int SHIFT_HOLD_MS = 1000;
	localparam int SHIFT_HOLD_CYC = CLK_HZ / 1000 * SHIFT_HOLD_MS;
	localparam int BLINK_MS = 250;
	localparam int BLINK_CYC = CLK_HZ / 1000 * BLINK_MS;
	localparam int MINUTE_S = 60;
	localparam int MINUTE_CYC = CLK_HZ * MINUTE_S;

	localparam logic [6:0] MIN_LEN = 7'd8;
	localparam logic [6:0] MAX_LEN = 7'd64;
	localparam logic [6:0] LEN_OVER = 7'd65;
	localparam logic [6:0] AL_OFF = 7'd0;
	localparam logic [6:0] AL_MIN = 7'd5;
	localparam logic [6:0] AL_MAX = 7'd99;
	localparam logic [6:0] AL_RESET = 7'd0;

	localparam logic [3:0] KEY_SETUP = 4'h1;
	localparam logic [3:0] KEY_AUTOLOCK = 4'h5;
	localparam logic [3:0] KEY_SD_DEL = 4'h6;

	localparam logic [1:0] SLOT_ADMIN = 2'h0;
	localparam logic [1:0] SLOT_USER = 2'h1;
	localparam logic [1:0] SLOT_SD = 2'h2;
	localparam logic [1:0] SLOT_SCRATCH = 2'h3;

	localparam logic [3:0] REG_STATUS = 4'h0;
	localparam logic [3:0] REG_AUTOLOCK = 4'h4;
	localparam logic [3:0] REG_CTRL = 4'h8;
	localparam logic [3:0] REG_CODE = 4'hC;

	localparam int ST_STATE_LSB = 0;
	localparam int ST_ADMIN_BIT = 8;
	localparam int ST_USER_BIT = 9;
	localparam int ST_SD_BIT = 10;
	localparam int ST_UNLOCK_BIT = 11;
	localparam int CTRL_WIPE_BIT = 0;
	localparam int CODE_SYM_LSB = 0;
	localparam int CODE_IDX_LSB = 8;
	localparam int CODE_COMMIT_BIT = 31;

	typedef logic [4:0] kplc_sym_t;

	typedef enum logic [4:0] {
		ST_LOCKED, ST_ADMIN, ST_SDDEL_PEND, ST_SDDEL_ACK, ST_SD_ENTRY, ST_SD_ACK,
		ST_UNLOCKED, ST_SETUP1, ST_SETUP_BLINK, ST_SETUP2, ST_SETUP_OK,
		ST_AL_TENS, ST_AL_UNITS, ST_AL_COMMIT, ST_AL_ACK, ST_ERR
	} kplc_state_t;

	function automatic logic [3:0] kplc_succ(input logic [3:0] d);
		return (d == 4'h9) ? 4'h0 : 4'(d + 4'h1);
	endfunction

	function automatic logic [3:0] kplc_pred(input logic [3:0] d);
		return (d == 4'h0) ? 4'h9 : 4'(d - 4'h1);
	endfunction

	function automatic logic [6:0] kplc_two_digit(input logic [3:0] t, input logic [3:0] u);
		return 7'({3'h0, t} * 7'd10 + {3'h0, u});
	endfunction
endpackage

// [kplc_code_mem.sv]
// Code symbol store with registered read data
`timescale 1ns/1ns
module kplc_code_mem #(
	parameter int WIDTH = 5,
	parameter int AW = 8
) (
	input wire logic core_clk,
	input wire logic wrEn,
	input wire logic [AW-1:0] wrAddr,
	input wire logic [WIDTH-1:0] wrData,
	input wire logic [AW-1:0] rdAddr,
	output logic [WIDTH-1:0] rdData
);
	logic [WIDTH-1:0] mem [0:(1<<AW)-1];

	always_ff @(posedge core_clk) begin
		if (wrEn) begin
			mem[wrAddr] <= wrData;
		end
	end

	always_ff @(posedge core_clk) begin
		rdData <= mem[rdAddr];
	end
endmodule // kplc_code_mem

// [kplc_keypad_lock_sva.sv]
// Port-level assertions for the keypad lock controller
`timescale 1ns/1ns
module kplc_keypad_lock_sva #(
	parameter int SHIFT_HOLD_CYCLES = 10
) (
	input wire logic core_clk,
	input wire logic rst_b,
	input wire logic keyPress,
	input wire logic keyDigitValid,
	input wire logic [3:0] keyDigit,
	input wire logic keyShift,
	input wire logic keyUnlock,
	input wire logic shiftHeld,
	input wire logic wipeEvent,
	input wire logic regWrEn,
	input wire logic ledRed,
	input wire logic ledGreen,
	input wire logic ledBlue,
	input wire logic driveUnlocked,
	input wire logic adminMode,
	input wire logic cryptoErase
);
	import kplc_pkg::*;
	int holdCnt;
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!rst_b);
	// Counts shift-alone samples seen while admin is shown
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) holdCnt <= 0;
		else holdCnt <= (adminMode && shiftHeld) ? holdCnt + 1 : 0;
	end
	a_shift_exit_admin: assert property (holdCnt == SHIFT_HOLD_CYCLES |-> ##[0:4] !adminMode)
		else $error("admin mode kept after long shift hold");
	a_sd_del_red: assert property (keyPress && keyShift && keyDigitValid && keyDigit == KEY_SD_DEL && !keyUnlock
		&& adminMode && !$past(keyPress) && !$past(shiftHeld) && !$past(regWrEn) |-> ##2 (!ledBlue && !ledGreen))
		else $error("delete request did not leave blue");
	a_wipe_erase: assert property (wipeEvent |-> ##[1:2] cryptoErase)
		else $error("wipe gave no erase pulse");
	a_wipe_standby: assert property (wipeEvent |-> ##[1:3] (ledRed && !adminMode && !driveUnlocked))
		else $error("wipe did not settle in standby");
	a_erase_single: assert property (cryptoErase && !wipeEvent && !regWrEn |=> !cryptoErase)
		else $error("erase pulse longer than one cycle");
	a_mode_excl: assert property (!(adminMode && driveUnlocked))
		else $error("admin and unlocked together");
	a_unlock_green: assert property ($rose(driveUnlocked) |-> ##[0:2] (ledGreen && !ledRed && !ledBlue))
		else $error("unlocked without steady green");
	a_admin_blue: assert property ($rose(adminMode) |-> ##[0:2] (ledBlue && !ledRed && !ledGreen))
		else $error("admin mode without steady blue");
	c_admin: cover property ($rose(adminMode));
	c_unlock: cover property ($rose(driveUnlocked));
	c_erase: cover property (cryptoErase);
endmodule // kplc_keypad_lock_sva

bind kplc_keypad_lock kplc_keypad_lock_sva #(.SHIFT_HOLD_CYCLES(SHIFT_HOLD_CYCLES)) i_sva (
	.core_clk(core_clk), .rst_b(rst_b), .keyPress(keyPress), .keyDigitValid(keyDigitValid),
	.keyDigit(keyDigit), .keyShift(keyShift), .keyUnlock(keyUnlock), .shiftHeld(shiftHeld),
	.wipeEvent(wipeEvent), .regWrEn(regWrEn), .ledRed(ledRed), .ledGreen(ledGreen), .ledBlue(ledBlue),
	.driveUnlocked(driveUnlocked), .adminMode(adminMode), .cryptoErase(cryptoErase));

// [kplc_operator.sv]
// Operator model pressing key combinations on the keypad
`timescale 1ns/1ns
module kplc_operator
	import kplc_pkg::*;
(
	input wire logic core_clk,
	output logic keyPress,
	output logic keyDigitValid,
	output logic [3:0] keyDigit,
	output logic keyShift,
	output logic keyUnlock,
	output logic shiftHeld
);
	kplc_sym_t pin[0:64];
	initial begin
		keyPress = 1'b0;
		keyDigitValid = 1'b0;
		keyDigit = 4'h0;
		keyShift = 1'b0;
		keyUnlock = 1'b0;
		shiftHeld = 1'b0;
	end
	// Fields scrambled between presses, nothing is promised there
	task automatic press(input logic sh, input logic un, input logic dv, input logic [3:0] d);
		@(posedge core_clk);
		keyPress <= 1'b1;
		keyShift <= sh;
		keyUnlock <= un;
		keyDigitValid <= dv;
		keyDigit <= d;
		@(posedge core_clk);
		keyPress <= 1'b0;
		keyShift <= !sh;
		keyUnlock <= !un;
		keyDigitValid <= !dv;
		keyDigit <= ~d;
	endtask
	task automatic pinEntry(input int n);
		for (int i = 0; i < n; i++) begin
			press(pin[i][4], 1'b0, 1'b1, pin[i][3:0]);
		end
		press(1'b0, 1'b1, 1'b0, 4'h0);
	endtask
	task automatic autolock(input logic [3:0] t, input logic [3:0] u);
		press(1'b0, 1'b1, 1'b1, KEY_AUTOLOCK);
		press(1'b0, 1'b0, 1'b1, t);
		press(1'b0, 1'b0, 1'b1, u);
		press(1'b1, 1'b0, 1'b0, 4'h0);
	endtask
	task automatic holdShift(input int n);
		@(posedge core_clk);
		shiftHeld <= 1'b1;
		repeat (n) @(posedge core_clk);
		shiftHeld <= 1'b0;
	endtask
endmodule // kplc_operator

// [test_keypad_pin_lock_control.sv]
// Self-checking bench for the keypad lock controller
`timescale 1ns/1ns
module test_keypad_pin_lock_control;
	import kplc_pkg::*;
	localparam int ACK = 20;
	localparam int BLK = 4;
	localparam int HOLD = 10;
	localparam int MIN = 50;
	localparam logic [31:0] ALL = 32'hFFFFFFFF;
	localparam logic [31:0] ADM = 32'h1 << ST_ADMIN_BIT;
	localparam logic [31:0] USR = 32'h1 << ST_USER_BIT;
	localparam logic [31:0] SDB = 32'h1 << ST_SD_BIT;
	localparam logic [31:0] UNL = 32'h1 << ST_UNLOCK_BIT;
	logic core_clk, rst_b, keyPress, keyDigitValid, keyShift, keyUnlock, shiftHeld;
	logic [3:0] keyDigit, regAddr;
	logic dataActivity, wipeEvent, regWrEn, regRdEn, rdPend;
	logic [31:0] regWrData, regRdData, seed;
	logic ledRed, ledGreen, ledBlue, driveUnlocked, adminMode, cryptoErase;
	logic [63:0] rdQ[$];
	logic eraseQ[$];
	logic [6:0] alExp;
	int err_total, tests_run, lens[5], modes[5], t, u;
	kplc_keypad_lock #(.ACK_CYCLES(ACK), .BLINK_CYCLES(BLK), .SHIFT_HOLD_CYCLES(HOLD), .MINUTE_CYCLES(MIN)) i_dut (
		.core_clk(core_clk), .rst_b(rst_b), .keyPress(keyPress), .keyDigitValid(keyDigitValid),
		.keyDigit(keyDigit), .keyShift(keyShift), .keyUnlock(keyUnlock), .shiftHeld(shiftHeld),
		.dataActivity(dataActivity), .wipeEvent(wipeEvent), .regAddr(regAddr), .regWrData(regWrData),
		.regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData(regRdData), .ledRed(ledRed), .ledGreen(ledGreen),
		.ledBlue(ledBlue), .driveUnlocked(driveUnlocked), .adminMode(adminMode), .cryptoErase(cryptoErase));
	kplc_operator i_op (.core_clk(core_clk), .keyPress(keyPress), .keyDigitValid(keyDigitValid),
		.keyDigit(keyDigit), .keyShift(keyShift), .keyUnlock(keyUnlock), .shiftHeld(shiftHeld));
	task automatic end_sim();
		if (err_total == 0 && tests_run > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	task automatic chkWord(input string nm, input logic [31:0] m, input logic [31:0] e, input logic [31:0] s);
		tests_run++;
		if ((s & m) !== e) begin
			err_total++;
			$display("ERROR %s expected %h seen %h", nm, e, s & m);
		end
	endtask
	task automatic chkBit(input string nm, input logic e, input logic s);
		tests_run++;
		if (s !== e) begin
			err_total++;
			$display("ERROR %s expected %b seen %b", nm, e, s);
		end
	endtask
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	function automatic kplc_sym_t sdSym(input int i);
		return {1'b0, 4'((i * 3 + 1) % 10)};
	endfunction
	task automatic idle(input int n);
		repeat (n) @(posedge core_clk);
	endtask
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge core_clk);
		regAddr <= a;
		regWrData <= d;
		regWrEn <= 1'b1;
		@(posedge core_clk);
		regWrEn <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e);
		rdQ.push_back({m, e});
		@(posedge core_clk);
		regAddr <= a;
		regRdEn <= 1'b1;
		@(posedge core_clk);
		regRdEn <= 1'b0;
	endtask
	// Random codes lead with a shifted symbol so they never form a run
	task automatic fill(input int n, input int mode);
		for (int i = 0; i < n; i++) begin
			case (mode)
				0: i_op.pin[i] = {i == 0, 4'(rnd() % 10)};
				1: i_op.pin[i] = 5'h03;
				2: i_op.pin[i] = {1'b0, 4'((7 + i) % 10)};
				3: i_op.pin[i] = {1'b0, 4'((18 - i) % 10)};
				default: i_op.pin[i] = sdSym(i);
			endcase
		end
	endtask
	task automatic setup(input int n, input logic bad, input kplc_state_t mid);
		i_op.press(1'b1, 1'b0, 1'b1, KEY_SETUP);
		i_op.pinEntry(n);
		idle(BLK * 3);
		rd(REG_STATUS, 32'h1F, 32'(mid));
		i_op.pin[0][4] = i_op.pin[0][4] ^ bad;
		i_op.pinEntry(n);
		i_op.pin[0][4] = i_op.pin[0][4] ^ bad;
		idle(ACK * 3);
	endtask
	task automatic sdProg();
		for (int i = 0; i < 8; i++) begin
			wr(REG_CODE, (i == 7 ? 32'h80000000 : 32'h0) | 32'(i << CODE_IDX_LSB) | 32'(sdSym(i)));
		end
	endtask
	initial begin
		core_clk = 1'b0;
		forever #20 core_clk = ~core_clk;
	end
	// Results appear the cycle after the read strobe
	always @(posedge core_clk) begin
		if (rdPend) begin
			chkWord("regRdData", rdQ[0][63:32], rdQ[0][31:0], regRdData);
			void'(rdQ.pop_front());
		end
		if (cryptoErase === 1'b1) begin
			chkBit("cryptoErase", eraseQ.size() > 0, 1'b1);
			if (eraseQ.size() > 0) void'(eraseQ.pop_front());
		end
		rdPend <= regRdEn;
	end
	// Span far above the whole sequence
	initial begin
		repeat (40000) @(posedge core_clk);
		err_total++;
		end_sim();
	end
	initial begin
		rst_b = 1'b0;
		dataActivity = 1'b0;
		wipeEvent = 1'b0;
		regAddr = 4'h0;
		regWrData = 32'h0;
		regWrEn = 1'b0;
		regRdEn = 1'b0;
		seed = 32'h0000A14C;
		lens = '{7, 65, 8, 10, 8};
		modes = '{0, 0, 1, 2, 3};
		repeat (8) @(posedge core_clk);
		rst_b <= 1'b1;
		rd(REG_STATUS, ALL, 32'h0);
		rd(REG_AUTOLOCK, ALL, 32'h0);
		rd(4'h2, ALL, 32'h0);
		eraseQ.push_back(1'b1);
		wr(REG_CTRL, 32'h1);
		rd(REG_STATUS, ALL, 32'h0);
		for (int k = 0; k < 5; k++) begin
			fill(lens[k], modes[k]);
			setup(lens[k], 1'b0, ST_ERR);
			rd(REG_STATUS, ALL, 32'h0);
		end
		fill(8, 0);
		setup(8, 1'b1, ST_SETUP2);
		rd(REG_STATUS, ALL, 32'h0);
		fill(64, 0);
		setup(64, 1'b0, ST_SETUP2);
		rd(REG_STATUS, ALL, 32'(ST_ADMIN) | ADM);
		alExp = AL_RESET;
		for (int k = 0; k < 6; k++) begin
			t = (k == 0) ? 9 : 0;
			u = (k == 0) ? 9 : (k == 1) ? 3 : (k == 2) ? 0 : (k == 3) ? 4 : 5;
			if (k == 4) begin
				u = 5 + rnd() % 95;
				t = u / 10;
				u = u % 10;
			end
			i_op.autolock(4'(t), 4'(u));
			idle(ACK * 3);
			if (t * 10 + u == 0 || t * 10 + u >= 5) alExp = 7'(t * 10 + u);
			rd(REG_AUTOLOCK, ALL, 32'(alExp));
		end
		sdProg();
		rd(REG_STATUS, ALL, 32'(ST_ADMIN) | ADM | SDB);
		i_op.press(1'b1, 1'b0, 1'b1, KEY_SD_DEL);
		idle(4);
		rd(REG_STATUS, 32'h1F, 32'(ST_SDDEL_PEND));
		i_op.press(1'b1, 1'b0, 1'b1, KEY_SD_DEL);
		idle(ACK * 3);
		rd(REG_STATUS, ALL, 32'(ST_ADMIN) | ADM);
		i_op.holdShift(HOLD + 2);
		idle(4);
		rd(REG_STATUS, ALL, 32'(ST_LOCKED) | ADM);
		i_op.pinEntry(64);
		idle(4);
		rd(REG_STATUS, ALL, 32'(ST_ADMIN) | ADM);
		i_op.holdShift(HOLD + 2);
		i_op.press(1'b1, 1'b1, 1'b0, 4'h0);
		idle(4);
		rd(REG_STATUS, ALL, 32'(ST_LOCKED) | ADM);
		sdProg();
		i_op.press(1'b1, 1'b1, 1'b0, 4'h0);
		idle(4);
		rd(REG_STATUS, 32'h1F, 32'(ST_SD_ENTRY));
		fill(8, 4);
		eraseQ.push_back(1'b1);
		i_op.pinEntry(8);
		idle(ACK * 3);
		rd(REG_STATUS, ~SDB, 32'(ST_UNLOCKED) | USR | UNL);
		// Random host traffic keeps the drive open; five idle minutes lock it
		repeat (300) begin
			@(posedge core_clk);
			dataActivity <= ^rnd();
		end
		@(posedge core_clk);
		dataActivity <= 1'b1;
		@(posedge core_clk);
		dataActivity <= 1'b0;
		rd(REG_STATUS, ALL, 32'(ST_UNLOCKED) | USR | UNL);
		idle(5 * MIN - 30);
		rd(REG_STATUS, ALL, 32'(ST_UNLOCKED) | USR | UNL);
		idle(40);
		rd(REG_STATUS, ALL, 32'(ST_LOCKED) | USR);
		eraseQ.push_back(1'b1);
		@(posedge core_clk);
		wipeEvent <= 1'b1;
		@(posedge core_clk);
		wipeEvent <= 1'b0;
		idle(4);
		rd(REG_STATUS, ALL, 32'h0);
		idle(4);
		chkBit("eraseQ", eraseQ.size() == 0, 1'b1);
		end_sim();
	end
endmodule // test_keypad_pin_lock_control
